// ---- verilog/apsc_map.vh ----
// Register offsets, field positions and reset values of the config bank
`ifndef APSC_MAP_VH
`define APSC_MAP_VH
`define APSC_ADDR_W 13
`define APSC_OFF_PATT1_LO 13'h0019
`define APSC_OFF_PATT1_HI 13'h001A
`define APSC_OFF_PATT2_LO 13'h001B
`define APSC_OFF_PATT2_HI 13'h001C
`define APSC_OFF_SIG_LO 13'h0024
`define APSC_OFF_FEATURES 13'h002A
`define APSC_OFF_OUT_ASSIGN 13'h002E
`define APSC_OFF_SYNC_CTRL 13'h0100
`define APSC_OFF_MISC_CTRL 13'h0101
`define APSC_RST_PATT 8'h00
`define APSC_RST_FEATURES 8'h01
`define APSC_RST_ASSIGN_A 1'h0
`define APSC_RST_ASSIGN_B 1'h1
`define APSC_RST_SYNC 8'h01
`define APSC_RST_MISC 8'h88
`define APSC_RST_OR_EN 1'h1
`define APSC_RST_OEB 1'h1
`define APSC_RST_OSC_RUN 1'h0
`define APSC_RST_PULLDOWN 1'h0
`define APSC_RST_RDATA 8'h00
`define APSC_BIT_OR_EN 0
`define APSC_BIT_MASTER_SYNC 0
`define APSC_BIT_DIV_SYNC 1
`define APSC_BIT_NEXT_ONLY 2
`define APSC_BIT_OEB_EN 7
`define APSC_BIT_OSC_DETECT 3
`define APSC_BIT_OSC_RUN 2
`define APSC_BIT_PULLDOWN_DIS 0
`define APSC_BIT_ASSIGN 0
`define APSC_SYNC_MASK 8'h07
`define APSC_MISC_MASK 8'h8D
`endif

// ---- verilog/apsc_sync2.v ----
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module apsc_sync2 (
    input wire mclk,
    input wire rst_b,
    input wire din,
    output reg dout
);
    reg meta_q;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'h0;
            dout <= 1'h0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // apsc_sync2

// ---- verilog/apsc_config_regs.v ----
// Pattern, sync and misc configuration register bank
// Functional notes
// - Pattern one: two bytes, reset zero
// - Pattern two: two bytes, reset zero
// - Overrange enable resets one, per indexed channel
// - Sync control resets 0x01, bits 7:3 reserved
// - No sync without master enable
// - Master plus divider enable: continuous sync pulses
// - Next-only: first pulse, then divider enable clears
// - Oscillator on when slow-detected or forced
`timescale 1ns/1ps
`include "apsc_map.vh"
module apsc_config_regs (
    input wire mclk,
    input wire rst_b,
    input wire [12:0] regAddr,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regWdata,
    input wire [1:0] chanIndex,
    input wire [7:0] signatureIn,
    input wire syncPin,
    input wire slowClockPin,
    output reg [7:0] regRdata,
    output reg [15:0] patternOne,
    output reg [15:0] patternTwo,
    output reg orEnableA,
    output reg orEnableB,
    output reg assignA,
    output reg assignB,
    output reg divSyncPulse,
    output reg oebPinEnable,
    output reg oscRun,
    output reg pulldownDisable
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    wire syncS;
    wire slowS;
    apsc_sync2 uSyncPin (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(syncPin),
        .dout(syncS)
    );
    apsc_sync2 uSlowPin (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(slowClockPin),
        .dout(slowS)
    );

    // ==========================================================
    // Register storage
    // ==========================================================
    reg [7:0] patt1Lo_q;
    reg [7:0] patt1Hi_q;
    reg [7:0] patt2Lo_q;
    reg [7:0] patt2Hi_q;
    reg orEnA_q;
    reg orEnB_q;
    reg asgA_q;
    reg asgB_q;
    reg [7:0] sync_q;
    reg [7:0] sync_d;
    reg [7:0] misc_q;
    reg syncPrev_q;
    wire wrSync;
    wire syncEdge;
    wire selA;
    wire selB;
    wire wrFeat;
    wire wrAsg;
    wire wrMisc;
    wire masterOn;
    wire divOn;
    wire nextOnly;
    wire syncFire;
    reg [7:0] rdMux;

    assign selA = chanIndex[0];
    assign selB = chanIndex[1];
    assign wrSync = regWr && (regAddr == `APSC_OFF_SYNC_CTRL);
    assign wrFeat = regWr && (regAddr == `APSC_OFF_FEATURES);
    assign wrAsg = regWr && (regAddr == `APSC_OFF_OUT_ASSIGN);
    assign wrMisc = regWr && (regAddr == `APSC_OFF_MISC_CTRL);
    assign syncEdge = syncS && !syncPrev_q;

    // Pattern bytes are plain storage; a pair is not written atomically
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            patt1Lo_q <= `APSC_RST_PATT;
            patt1Hi_q <= `APSC_RST_PATT;
            patt2Lo_q <= `APSC_RST_PATT;
            patt2Hi_q <= `APSC_RST_PATT;
        end else if (regWr) begin
            case (regAddr)
                `APSC_OFF_PATT1_LO: patt1Lo_q <= regWdata;
                `APSC_OFF_PATT1_HI: patt1Hi_q <= regWdata;
                `APSC_OFF_PATT2_LO: patt2Lo_q <= regWdata;
                `APSC_OFF_PATT2_HI: patt2Hi_q <= regWdata;
                default: ;
            endcase
        end
    end

    // Features and output assign are banked; index bits pick the channels
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            orEnA_q <= `APSC_RST_OR_EN;
            orEnB_q <= `APSC_RST_OR_EN;
            asgA_q <= `APSC_RST_ASSIGN_A;
            asgB_q <= `APSC_RST_ASSIGN_B;
        end else begin
            if (wrFeat && selA) orEnA_q <= regWdata[`APSC_BIT_OR_EN];
            if (wrFeat && selB) orEnB_q <= regWdata[`APSC_BIT_OR_EN];
            if (wrAsg && selA) asgA_q <= regWdata[`APSC_BIT_ASSIGN];
            if (wrAsg && selB) asgB_q <= regWdata[`APSC_BIT_ASSIGN];
        end
    end

    // Open bits of the misc register are dropped at the write
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            misc_q <= `APSC_RST_MISC;
        end else if (wrMisc) begin
            misc_q <= regWdata & `APSC_MISC_MASK;
        end
    end

    // ==========================================================
    // Sync control and divider pulse
    // ==========================================================
    // A sync edge reaches the divider only with master and divider on
    assign masterOn = sync_q[`APSC_BIT_MASTER_SYNC];
    assign divOn = sync_q[`APSC_BIT_DIV_SYNC];
    assign nextOnly = sync_q[`APSC_BIT_NEXT_ONLY];
    assign syncFire = syncEdge && masterOn && divOn;

    always @* begin
        sync_d = sync_q;
        if (wrSync) begin
            sync_d = regWdata & `APSC_SYNC_MASK;
        end
        // Self-clear after a one-shot alignment wins over a write
        if (syncFire && nextOnly) begin
            sync_d[`APSC_BIT_DIV_SYNC] = 1'h0;
        end
    end

    // The divider pulse lasts one cycle per accepted sync edge
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= `APSC_RST_SYNC;
            syncPrev_q <= 1'h0;
            divSyncPulse <= 1'h0;
        end else begin
            sync_q <= sync_d;
            syncPrev_q <= syncS;
            divSyncPulse <= syncFire;
        end
    end

    // ==========================================================
    // Read data select
    // ==========================================================
    always @* begin
        rdMux = `APSC_RST_RDATA;
        case (regAddr)
            `APSC_OFF_PATT1_LO: rdMux = patt1Lo_q;
            `APSC_OFF_PATT1_HI: rdMux = patt1Hi_q;
            `APSC_OFF_PATT2_LO: rdMux = patt2Lo_q;
            `APSC_OFF_PATT2_HI: rdMux = patt2Hi_q;
            `APSC_OFF_SIG_LO: rdMux = signatureIn;
            // Banked fields read back channel B when its index bit is set
            `APSC_OFF_FEATURES:
                rdMux = {7'h00, selB ? orEnB_q : orEnA_q};
            `APSC_OFF_OUT_ASSIGN:
                rdMux = {7'h00, selB ? asgB_q : asgA_q};
            `APSC_OFF_SYNC_CTRL: rdMux = sync_q;
            `APSC_OFF_MISC_CTRL: rdMux = misc_q;
            default: rdMux = `APSC_RST_RDATA;
        endcase
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            patternOne <= {`APSC_RST_PATT, `APSC_RST_PATT};
            patternTwo <= {`APSC_RST_PATT, `APSC_RST_PATT};
            orEnableA <= `APSC_RST_OR_EN;
            orEnableB <= `APSC_RST_OR_EN;
            assignA <= `APSC_RST_ASSIGN_A;
            assignB <= `APSC_RST_ASSIGN_B;
            oebPinEnable <= `APSC_RST_OEB;
            oscRun <= `APSC_RST_OSC_RUN;
            pulldownDisable <= `APSC_RST_PULLDOWN;
        end else begin
            patternOne <= {patt1Hi_q, patt1Lo_q};
            patternTwo <= {patt2Hi_q, patt2Lo_q};
            orEnableA <= orEnA_q;
            orEnableB <= orEnB_q;
            assignA <= asgA_q;
            assignB <= asgB_q;
            oebPinEnable <= misc_q[`APSC_BIT_OEB_EN];
            oscRun <= misc_q[`APSC_BIT_OSC_RUN] ||
                (misc_q[`APSC_BIT_OSC_DETECT] && slowS);
            pulldownDisable <= misc_q[`APSC_BIT_PULLDOWN_DIS];
        end
    end

    // Read data holds until the next read strobe
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= `APSC_RST_RDATA;
        end else if (regRd) begin
            regRdata <= rdMux;
        end
    end
endmodule // apsc_config_regs

// ---- tb/apsc_host_model.sv ----
// Host model that drives the register strobe port
`timescale 1ns/1ps
module apsc_host_model (
    input wire mclk,
    output reg [12:0] regAddr,
    output reg regWr,
    output reg regRd,
    output reg [7:0] regWdata
);
    initial {regAddr, regWr, regRd, regWdata} = 23'h0;
    // One strobe edge, then released data is inverted
    task acc(input w, input [12:0] a, input [7:0] d);
        begin
            @(posedge mclk) #1;
            {regAddr, regWr, regRd, regWdata} = {a, w, !w, d};
            @(posedge mclk) #1;
            {regWr, regRd, regWdata} = {2'h0, ~d};
        end
    endtask
endmodule // apsc_host_model

// ---- tb/apsc_config_regs_properties.sv ----
// Port checker for the config register bank
`timescale 1ns/1ps
module apsc_config_regs_properties (
    input wire mclk,
    input wire rst_b,
    input wire [12:0] regAddr,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regWdata,
    input wire [1:0] chanIndex,
    input wire [7:0] regRdata,
    input wire [15:0] patternOne,
    input wire [15:0] patternTwo,
    input wire orEnableA,
    input wire divSyncPulse,
    input wire oscRun
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    reg mstEn_q;
    always @(posedge mclk or negedge rst_b)
        if (!rst_b) mstEn_q <= 1'b1;
        else if (regWr && regAddr == 13'h0100) mstEn_q <= regWdata[0];
    // Marks a one-shot alignment already spent since the last sync write
    reg nxt_q;
    reg nxtDly_q;
    reg shotDone_q;
    always @(posedge mclk or negedge rst_b)
        if (!rst_b) begin
            nxt_q <= 1'b0;
            nxtDly_q <= 1'b0;
            shotDone_q <= 1'b0;
        end else begin
            nxtDly_q <= nxt_q;
            if (regWr && regAddr == 13'h0100) begin
                nxt_q <= regWdata[2];
                shotDone_q <= 1'b0;
            end else if (divSyncPulse && nxtDly_q) shotDone_q <= 1'b1;
        end
    p1_low_a: assert property (regWr && regAddr == 13'h0019 |->
        ##2 patternOne[7:0] == $past(regWdata, 2)) else $error("p1 lo");
    p1_high_a: assert property (regWr && regAddr == 13'h001A |->
        ##2 patternOne[15:8] == $past(regWdata, 2)) else $error("p1 hi");
    p2_low_a: assert property (regWr && regAddr == 13'h001B |->
        ##2 patternTwo[7:0] == $past(regWdata, 2)) else $error("p2 lo");
    p2_high_a: assert property (regWr && regAddr == 13'h001C |->
        ##2 patternTwo[15:8] == $past(regWdata, 2)) else $error("p2 hi");
    or_enable_a: assert property (regWr && regAddr == 13'h002A &&
        chanIndex[0] |-> ##2 orEnableA == $past(regWdata[0], 2))
        else $error("or en");
    sync_rsvd_a: assert property ($past(regRd) &&
        $past(regAddr) == 13'h0100 |-> regRdata[7:3] == 5'h00)
        else $error("sync rsvd");
    no_sync_a: assert property (divSyncPulse |-> $past(mstEn_q))
        else $error("sync off");
    one_shot_a: assert property (divSyncPulse |-> !shotDone_q)
        else $error("second pulse");
    pulse_once_a: assert property (divSyncPulse |=> !divSyncPulse)
        else $error("long pulse");
    osc_force_a: assert property (regWr && regAddr == 13'h0101 &&
        regWdata[2] |-> ##2 oscRun) else $error("osc run");
    cover property (divSyncPulse);
    cover property (oscRun);
    cover property (divSyncPulse && nxtDly_q);
    cover property (regWr && regAddr == 13'h0100);
endmodule // apsc_config_regs_properties
bind apsc_config_regs apsc_config_regs_properties u_chk (.mclk, .rst_b,
    .regAddr, .regWr, .regRd, .regWdata, .chanIndex, .regRdata,
    .patternOne, .patternTwo, .orEnableA, .divSyncPulse, .oscRun);

// ---- tb/testbench.sv ----
// Self-checking bench for the config register bank
`timescale 1ns/1ps
module testbench;
    reg mclk = 0, rst_b = 0, syncPin = 0, slowClockPin = 0;
    reg [1:0] chanIndex = 2'h3;
    reg [7:0] signatureIn = 8'h3C;
    wire [12:0] regAddr;
    wire regWr, regRd, orEnableA, orEnableB, assignA, assignB;
    wire divSyncPulse, oscRun, oebPinEnable, pulldownDisable;
    wire [7:0] regWdata, regRdata;
    wire [15:0] patternOne, patternTwo;
    integer errors = 0, tests_run = 0, pulses = 0;
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (divSyncPulse === 1'b1) pulses = pulses + 1;
    apsc_host_model h (.mclk, .regAddr, .regWr, .regRd, .regWdata);
    apsc_config_regs dut (.mclk, .rst_b, .regAddr, .regWr, .regRd,
        .regWdata, .chanIndex, .signatureIn, .syncPin, .slowClockPin,
        .regRdata, .patternOne, .patternTwo, .orEnableA, .orEnableB,
        .assignA, .assignB, .divSyncPulse, .oebPinEnable, .oscRun,
        .pulldownDisable);
    task chk(input [63:0] n, input [15:0] s, input [15:0] e);
        begin
            tests_run = tests_run + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("BAD %0s exp %h seen %h", n, e, s);
            end
        end
    endtask
    task wr(input [12:0] a, input [7:0] d);
        h.acc(1'b1, a, d);
    endtask
    task rd(input [12:0] a);
        h.acc(1'b0, a, 8'h00);
    endtask
    task step(input integer n);
        repeat (n) @(posedge mclk) #1;
    endtask
    // Sync edge held long enough to pass the two-flop synchroniser
    task pulse;
        begin
            syncPin = 1'b1;
            step(3);
            syncPin = 1'b0;
            step(4);
        end
    endtask
    task t_patt;
        begin
            chk("p1rst", patternOne, 16'h0000);
            chk("p2rst", patternTwo, 16'h0000);
            wr(13'h0019, 8'hA5);
            wr(13'h001A, 8'h5A);
            wr(13'h001B, 8'h12);
            wr(13'h001C, 8'hC3);
            step(1);
            chk("p1", patternOne, 16'h5AA5);
            chk("p2", patternTwo, 16'hC312);
        end
    endtask
    task t_feat;
        begin
            chk("orrst", {orEnableA, orEnableB}, 16'h0003);
            chk("asrst", {assignA, assignB}, 16'h0001);
            chanIndex = 2'h1;
            wr(13'h002A, 8'h00);
            step(1);
            chk("or", {orEnableA, orEnableB}, 16'h0001);
            rd(13'h002A);
            chk("orrd", regRdata, 16'h0000);
            wr(13'h002E, 8'h01);
            rd(13'h002E);
            chk("asrd", regRdata, 16'h0001);
            chk("asab", {assignA, assignB}, 16'h0003);
            chanIndex = 2'h2;
            rd(13'h002A);
            chk("orrdb", regRdata, 16'h0001);
            wr(13'h002E, 8'h00);
            step(1);
            chk("asb", {assignA, assignB}, 16'h0002);
            wr(13'h0024, 8'hFF);
            rd(13'h0024);
            chk("sig", regRdata, 16'h003C);
            rd(13'h0101);
            chk("misc", regRdata, 16'h0088);
        end
    endtask
    task t_sync;
        begin
            rd(13'h0100);
            chk("syrst", regRdata, 16'h0001);
            wr(13'h0100, 8'hFA);
            rd(13'h0100);
            chk("syrsv", regRdata, 16'h0002);
            pulse;
            chk("nomst", pulses, 16'h0000);
            wr(13'h0100, 8'h03);
            pulse;
            pulse;
            chk("cont", pulses, 16'h0002);
            wr(13'h0100, 8'h07);
            pulse;
            pulse;
            chk("next", pulses, 16'h0003);
            rd(13'h0100);
            chk("clr", regRdata, 16'h0005);
        end
    endtask
    task t_osc;
        begin
            chk("oebrst", {oebPinEnable, pulldownDisable}, 16'h0002);
            wr(13'h0101, 8'h08);
            slowClockPin = 1'b1;
            step(5);
            chk("det", oscRun, 16'h0001);
            chk("oeboff", {oebPinEnable, pulldownDisable}, 16'h0000);
            slowClockPin = 1'b0;
            step(5);
            chk("idle", oscRun, 16'h0000);
            wr(13'h0101, 8'h04);
            step(1);
            chk("run", oscRun, 16'h0001);
            wr(13'h0101, 8'hFF);
            rd(13'h0101);
            chk("miscmsk", regRdata, 16'h008D);
            chk("oebpd", {oebPinEnable, pulldownDisable}, 16'h0003);
        end
    endtask
    // Reset in mid-run must bring every register back to its default
    task t_rst;
        begin
            rst_b = 1'b0;
            step(2);
            rst_b = 1'b1;
            chk("rstp1", patternOne, 16'h0000);
            chk("rstp2", patternTwo, 16'h0000);
            chk("rstor", {orEnableA, orEnableB}, 16'h0003);
            chk("rstas", {assignA, assignB}, 16'h0001);
            chk("rstmsc", {oebPinEnable, pulldownDisable, oscRun}, 16'h0004);
            rd(13'h0100);
            chk("rstsy", regRdata, 16'h0001);
        end
    endtask
    task end_of_test;
        begin
            $display("errors %0d tests_run %0d", errors, tests_run);
            if (errors == 0 && tests_run > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        step(5);
        rst_b = 1'b1;
        t_patt;
        t_feat;
        t_sync;
        t_osc;
        t_rst;
        end_of_test;
    end
    initial begin
        #40000;
        errors = errors + 1;
        end_of_test;
    end
endmodule // testbench
